// ==== include/acs_pkg.sv ====
// acs_pkg: constants and carriers for the audio control sequencer
// assumes a 200 MHz pclk; the analyzer read clock is sampled as a plain input
// How it works
// - a falling edge on the read clock starts a read cycle
// - each later rising edge steps the level output to the next of seven bands
// - read clock held high for the reset time clears all band holders
// - each band holder keeps the maximum peak seen since the last reset-time hold of the read clock
// - soft-mute pin or bus command start the same sloped mute ramp
// - status bit 0 is set from mute start until demute completes
// - a running ramp completes; request changes are ignored until it ends
// - ramp duration is one of three programmable times
// - writing input-selector byte 0 starts offset cancel within the alignment time
// - keep-offset bit set: byte 0 write keeps old alignment, no cancel
// - fast-charge switch stays on after reset until first byte 0 access
// - soft-step blends each step over one of four programmable times
// - test mode needs both the test entry bit and testing byte bit 0
// - volume spans +32 dB to -79.5 dB in 0.5 dB steps
// - input gain spans 0 to 15 dB in 1 dB steps
// - centre frequency selectable only on equalizer bands 1, 6 and 7
// - each equalizer band has an independent four-way quality factor
package acs_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned NUM_BANDS        = 7;
  localparam int unsigned PEAK_W           = 8;
  localparam int unsigned INTRES_MS        = 3;
  localparam int unsigned INTRES_CYC       = INTRES_MS * 1000 * CLK_MHZ;
  localparam int unsigned AZ_US_X10        = 3000;  // 0.3 ms in units of 0.1 us
  localparam int unsigned AZ_CYC           = AZ_US_X10 * CLK_MHZ / 10;
  localparam int unsigned MUTE_T1_US_X100  = 48;    // 0.48 ms in 10 us units
  localparam int unsigned MUTE_T2_US_X100  = 96;
  localparam int unsigned MUTE_T3_US_X100  = 12300;
  localparam int unsigned MUTE_T1_CYC      = MUTE_T1_US_X100 * 10 * CLK_MHZ;
  localparam int unsigned MUTE_T2_CYC      = MUTE_T2_US_X100 * 10 * CLK_MHZ;
  localparam int unsigned MUTE_T3_CYC      = MUTE_T3_US_X100 * 10 * CLK_MHZ;
  localparam int unsigned STEP_T0_US       = 320;
  localparam int unsigned STEP_T1_US       = 1280;
  localparam int unsigned STEP_T2_US       = 5120;
  localparam int unsigned STEP_T3_US       = 20400;
  localparam int unsigned STEP_T0_CYC      = STEP_T0_US * CLK_MHZ;
  localparam int unsigned STEP_T1_CYC      = STEP_T1_US * CLK_MHZ;
  localparam int unsigned STEP_T2_CYC      = STEP_T2_US * CLK_MHZ;
  localparam int unsigned STEP_T3_CYC      = STEP_T3_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 25;    // longest mute ramp needs 25 bits
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL        = 12'h000;
  localparam logic [11:0] ADDR_STATUS      = 12'h004;
  localparam logic [11:0] ADDR_INSEL       = 12'h008;
  localparam logic [11:0] ADDR_VOLUME      = 12'h00C;
  localparam logic [11:0] ADDR_MUTECFG     = 12'h010;
  localparam logic [11:0] ADDR_STEPCFG     = 12'h014;
  localparam logic [11:0] ADDR_TEST        = 12'h018;
  localparam logic [11:0] ADDR_EQ0         = 12'h020;  // seven words from here
  // control word fields
  localparam int unsigned CTRL_KEEP_BIT    = 6;   // keep_offset_bit
  localparam int unsigned CTRL_TEST_BIT    = 7;   // test_entry_bit
  localparam int unsigned CTRL_MUTE_BIT    = 0;   // 1 requests soft mute
  // status word fields
  localparam int unsigned ST_MUTE_BIT      = 0;
  localparam int unsigned ST_AZ_BIT        = 1;
  localparam int unsigned ST_FC_BIT        = 2;
  localparam int unsigned ST_TEST_BIT      = 3;
  localparam int unsigned ST_STEP_BIT      = 4;
  // field limits
  localparam logic [7:0]  VOL_MAX_CODE     = 8'hDF;  // -79.5 dB
  localparam logic [3:0]  GAIN_RST         = 4'hF;   // 15 dB
  localparam logic [7:0]  VOL_RST          = 8'hDE;
  localparam logic [1:0]  MUTE_TIME_RST    = 2'h3;
  localparam logic [1:0]  STEP_TIME_RST    = 2'h0;

  typedef enum logic [1:0] {
    ACS_MUTE_OPEN,
    ACS_MUTE_DOWN,
    ACS_MUTE_HELD,
    ACS_MUTE_UP
  } acs_mute_st_t;

  typedef struct packed {
    logic       fsel;     // centre select, bands 1, 6, 7 only
    logic [1:0] qfac;     // four quality factors
    logic [4:0] level;
  } acs_eq_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } acs_bus_req_t;
endpackage : acs_pkg

// ==== rtl/acs_ramp.sv ====
// acs_ramp: counts a programmable ramp length, one pulse when done
// assumes start is a one-cycle pulse on pclk and is ignored while busy
`timescale 1ns/1ps
module acs_ramp (
  input  wire logic                     pclk,     // clock
  input  wire logic                     presetn,  // async reset, low
  input  wire logic                     start,    // begin a ramp
  input  wire logic [acs_pkg::CNT_W-1:0] length,  // cycles to run
  output logic                          busy,     // ramp running
  output logic                          done      // last cycle pulse
);
  logic [acs_pkg::CNT_W-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (start && cnt_q == '0) begin
      cnt_q <= length;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = (cnt_q == {{(acs_pkg::CNT_W-1){1'b0}}, 1'b1});
endmodule : acs_ramp

// ==== rtl/acs_peak_mem.sv ====
// acs_peak_mem: seven band peak holders with registered read
// assumes sample bands arrive on pclk; clear wins over capture
`timescale 1ns/1ps
module acs_peak_mem (
  input  wire logic                      pclk,     // clock
  input  wire logic                      presetn,  // async reset, low
  input  wire logic                      clear,    // clear all holders
  input  wire logic [acs_pkg::NUM_BANDS*acs_pkg::PEAK_W-1:0] level_in, // band levels
  input  wire logic [2:0]                rd_idx,   // band to read
  output logic      [acs_pkg::PEAK_W-1:0] rd_data  // registered level
);
  logic [acs_pkg::PEAK_W-1:0] hold_q [acs_pkg::NUM_BANDS];

  for (genvar b = 0; b < acs_pkg::NUM_BANDS; b++) begin : g_band
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hold_q[b] <= '0;
      end else if (clear) begin
        hold_q[b] <= '0;
      end else if (level_in[b*acs_pkg::PEAK_W +: acs_pkg::PEAK_W] > hold_q[b]) begin
        hold_q[b] <= level_in[b*acs_pkg::PEAK_W +: acs_pkg::PEAK_W];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (rd_idx < 3'(acs_pkg::NUM_BANDS)) begin
      rd_data <= hold_q[rd_idx];
    end else begin
      rd_data <= '0;
    end
  end
endmodule : acs_peak_mem

// ==== rtl/acs_top.sv ====
// acs_top: audio control sequencer, APB slave plus analyzer readout
// assumes APB master on pclk; read clock and mute pin asynchronous
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module acs_top #(
  parameter int unsigned INTRES_CYC = acs_pkg::INTRES_CYC,  // read clock reset hold
  parameter int unsigned AZ_CYC     = acs_pkg::AZ_CYC,      // alignment length
  parameter int unsigned MUTE_T1    = acs_pkg::MUTE_T1_CYC, // mute time 0
  parameter int unsigned MUTE_T2    = acs_pkg::MUTE_T2_CYC, // mute time 1
  parameter int unsigned MUTE_T3    = acs_pkg::MUTE_T3_CYC, // mute time 2
  parameter int unsigned STEP_T0    = acs_pkg::STEP_T0_CYC, // blend time 0
  parameter int unsigned STEP_T1    = acs_pkg::STEP_T1_CYC, // blend time 1
  parameter int unsigned STEP_T2    = acs_pkg::STEP_T2_CYC, // blend time 2
  parameter int unsigned STEP_T3    = acs_pkg::STEP_T3_CYC  // blend time 3
) (
  input  wire logic        pclk,                // clock
  input  wire logic        presetn,             // async reset, low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb enable
  input  wire logic        pwrite,              // apb direction
  input  wire logic [11:0] paddr,               // apb address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error
  input  wire logic        analyzer_read_clock, // host read clock
  input  wire logic        soft_mute_pin,       // low requests mute
  input  wire logic [acs_pkg::NUM_BANDS*acs_pkg::PEAK_W-1:0] band_level, // rectified bands
  output logic [acs_pkg::PEAK_W-1:0] analyzer_level_out, // selected band level
  output logic             mute_active,         // status bit 0 mirror
  output logic             mute_gain_down,      // ramp toward mute
  output logic             offset_cancel,       // alignment running
  output logic             common_input_return, // fast-charge switch on
  output logic             soft_step_busy,      // blend running
  output logic             test_mode,           // test signals to mix pin
  output logic [3:0]       input_gain,          // 0..15 dB
  output logic [7:0]       volume_code,         // +32..-79.5 dB
  output logic [acs_pkg::NUM_BANDS*8-1:0] eq_cfg // packed band settings
);
  // ---------- apb ----------
  acs_pkg::acs_bus_req_t req;
  logic access, wr_en, rd_en, mapped;
  assign req      = '{sel: psel, write: pwrite, addr: paddr, wdata: pwdata};
  assign access   = req.sel && penable;
  assign pready   = 1'b1;
  assign wr_en    = access && req.write && mapped;
  // read data registered in setup so it stands through the access edge
  assign rd_en    = req.sel && !penable && !req.write;
  assign pslverr  = access && !mapped;

  logic [7:0] ctrl_q, insel_q, volume_q, test_q;
  logic [2:0] mutecfg_q;
  logic [2:0] stepcfg_q;
  acs_pkg::acs_eq_t eq_q [acs_pkg::NUM_BANDS];
  logic eq_hit;
  logic [2:0] eq_idx;

  assign eq_idx = 3'(req.addr[4:2]);
  assign eq_hit = (req.addr >= acs_pkg::ADDR_EQ0) && (req.addr[11:5] == acs_pkg::ADDR_EQ0[11:5])
                  && (eq_idx < 3'(acs_pkg::NUM_BANDS)) && (req.addr[1:0] == 2'h0);

  always_comb begin
    mapped = 1'b1;
    unique case (req.addr)
      acs_pkg::ADDR_CTRL, acs_pkg::ADDR_STATUS, acs_pkg::ADDR_INSEL, acs_pkg::ADDR_VOLUME,
      acs_pkg::ADDR_MUTECFG, acs_pkg::ADDR_STEPCFG, acs_pkg::ADDR_TEST: mapped = 1'b1;
      default: mapped = eq_hit;
    endcase
  end

  // ---------- config registers ----------
  logic insel_wr;
  assign insel_wr = wr_en && req.addr == acs_pkg::ADDR_INSEL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= 8'h00;
      insel_q   <= {1'b1, acs_pkg::GAIN_RST, 3'h0};
      volume_q  <= acs_pkg::VOL_RST;
      test_q    <= 8'h00;
      mutecfg_q <= {acs_pkg::MUTE_TIME_RST, 1'b1};
      stepcfg_q <= {acs_pkg::STEP_TIME_RST, 1'b0};
    end else if (wr_en) begin
      unique case (req.addr)
        acs_pkg::ADDR_CTRL:    ctrl_q    <= req.wdata[7:0];
        acs_pkg::ADDR_INSEL:   insel_q   <= req.wdata[7:0];
        acs_pkg::ADDR_VOLUME: begin
          if (req.wdata[7:0] <= acs_pkg::VOL_MAX_CODE) begin
            volume_q <= req.wdata[7:0];
          end else begin
            volume_q <= acs_pkg::VOL_MAX_CODE;
          end
        end
        acs_pkg::ADDR_MUTECFG: mutecfg_q <= req.wdata[2:0];
        acs_pkg::ADDR_STEPCFG: stepcfg_q <= req.wdata[2:0];
        acs_pkg::ADDR_TEST:    test_q    <= req.wdata[7:0];
        default: ;
      endcase
    end
  end

  for (genvar b = 0; b < acs_pkg::NUM_BANDS; b++) begin : g_eq
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        eq_q[b] <= '0;
      end else if (wr_en && eq_hit && eq_idx == 3'(b)) begin
        eq_q[b].qfac  <= req.wdata[6:5];
        eq_q[b].level <= req.wdata[4:0];
        // only bands 1, 6, 7 keep a centre select
        eq_q[b].fsel  <= (b == 0 || b == 5 || b == 6) ? req.wdata[7] : 1'b0;
      end
    end
    assign eq_cfg[b*8 +: 8] = eq_q[b];
  end

  assign input_gain  = insel_q[6:3];
  assign volume_code = volume_q;
  assign test_mode   = ctrl_q[acs_pkg::CTRL_TEST_BIT] && test_q[0];

  // ---------- offset cancel and fast charge ----------
  logic az_start, az_busy, az_done, fc_q;
  assign az_start = insel_wr && !ctrl_q[acs_pkg::CTRL_KEEP_BIT];

  acs_ramp u_az (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (az_start),
    .length  (acs_pkg::CNT_W'(AZ_CYC)),
    .busy    (az_busy),
    .done    (az_done)
  );
  assign offset_cancel = az_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_q <= 1'b1;
    end else if (access && req.addr == acs_pkg::ADDR_INSEL) begin
      fc_q <= 1'b0;
    end
  end
  assign common_input_return = fc_q;

  // ---------- soft mute ----------
  logic [2:0] smp_q;
  logic       smp_req;
  logic       mute_req;
  acs_pkg::acs_mute_st_t mst_q;
  logic m_start, m_busy, m_done;
  logic [acs_pkg::CNT_W-1:0] m_len;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_q   <= 3'h7;
      smp_req <= 1'b0;
    end else begin
      smp_q <= {smp_q[1:0], soft_mute_pin};
      if (smp_q[2] == smp_q[1]) begin
        smp_req <= !smp_q[2];
      end
    end
  end

  // mute config bit 0 low is a bus mute command
  assign mute_req = smp_req || !mutecfg_q[0] || ctrl_q[acs_pkg::CTRL_MUTE_BIT];

  always_comb begin
    unique case (mutecfg_q[2:1])
      2'h0:    m_len = acs_pkg::CNT_W'(MUTE_T1);
      2'h1:    m_len = acs_pkg::CNT_W'(MUTE_T2);
      default: m_len = acs_pkg::CNT_W'(MUTE_T3);
    endcase
  end

  assign m_start = (mst_q == acs_pkg::ACS_MUTE_OPEN && mute_req)
                || (mst_q == acs_pkg::ACS_MUTE_HELD && !mute_req);

  acs_ramp u_mute (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (m_start),
    .length  (m_len),
    .busy    (m_busy),
    .done    (m_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_q <= acs_pkg::ACS_MUTE_OPEN;
    end else begin
      unique case (mst_q)
        acs_pkg::ACS_MUTE_OPEN: if (mute_req) mst_q <= acs_pkg::ACS_MUTE_DOWN;
        acs_pkg::ACS_MUTE_DOWN: if (m_done) mst_q <= acs_pkg::ACS_MUTE_HELD;
        acs_pkg::ACS_MUTE_HELD: if (!mute_req) mst_q <= acs_pkg::ACS_MUTE_UP;
        acs_pkg::ACS_MUTE_UP:   if (m_done) mst_q <= acs_pkg::ACS_MUTE_OPEN;
      endcase
    end
  end

  assign mute_active    = (mst_q != acs_pkg::ACS_MUTE_OPEN);
  assign mute_gain_down = (mst_q == acs_pkg::ACS_MUTE_DOWN) || (mst_q == acs_pkg::ACS_MUTE_HELD);

  // ---------- soft step ----------
  logic s_start;
  logic [acs_pkg::CNT_W-1:0] s_len;
  always_comb begin
    unique case (stepcfg_q[2:1])
      2'h0: s_len = acs_pkg::CNT_W'(STEP_T0);
      2'h1: s_len = acs_pkg::CNT_W'(STEP_T1);
      2'h2: s_len = acs_pkg::CNT_W'(STEP_T2);
      2'h3: s_len = acs_pkg::CNT_W'(STEP_T3);
    endcase
  end
  assign s_start = stepcfg_q[0] && wr_en && req.addr == acs_pkg::ADDR_VOLUME;

  acs_ramp u_step (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (s_start),
    .length  (s_len),
    .busy    (soft_step_busy),
    .done    ()
  );

  // ---------- analyzer readout ----------
  logic [2:0] sac_q;
  logic       sac_lvl_q;
  logic       sac_fall, sac_rise;
  logic [2:0] band_q;
  logic       cyc_q;
  logic [acs_pkg::CNT_W-1:0] hi_cnt_q;
  logic       sa_clear;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sac_q     <= 3'h7;
      sac_lvl_q <= 1'b1;
    end else begin
      sac_q <= {sac_q[1:0], analyzer_read_clock};
      if (sac_q[2] == sac_q[1]) begin
        sac_lvl_q <= sac_q[2];
      end
    end
  end
  assign sac_fall = (sac_q[2] == sac_q[1]) && !sac_q[2] && sac_lvl_q;
  assign sac_rise = (sac_q[2] == sac_q[1]) && sac_q[2] && !sac_lvl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q  <= 1'b0;
      band_q <= 3'h7;
    end else if (sac_fall && !cyc_q) begin
      cyc_q  <= 1'b1;
      band_q <= 3'h7;
    end else if (sac_rise && cyc_q) begin
      band_q <= (band_q == 3'h7 || band_q == 3'(acs_pkg::NUM_BANDS - 1)) ? 3'h0 : band_q + 3'h1;
    end else if (sa_clear) begin
      cyc_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_q <= '0;
    end else if (!sac_lvl_q) begin
      hi_cnt_q <= '0;
    end else if (hi_cnt_q != acs_pkg::CNT_W'(INTRES_CYC)) begin
      hi_cnt_q <= hi_cnt_q + 1'b1;
    end
  end
  assign sa_clear = sac_lvl_q && hi_cnt_q == acs_pkg::CNT_W'(INTRES_CYC - 1);

  acs_peak_mem u_peak (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (sa_clear),
    .level_in (band_level),
    .rd_idx   (band_q),
    .rd_data  (analyzer_level_out)
  );

  // ---------- read mux ----------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (req.addr)
        acs_pkg::ADDR_CTRL:    prdata <= {24'h000000, ctrl_q};
        acs_pkg::ADDR_STATUS:  prdata <= {27'h0, soft_step_busy, test_mode, fc_q, az_busy, mute_active};
        acs_pkg::ADDR_INSEL:   prdata <= {24'h000000, insel_q};
        acs_pkg::ADDR_VOLUME:  prdata <= {24'h000000, volume_q};
        acs_pkg::ADDR_MUTECFG: prdata <= {29'h0, mutecfg_q};
        acs_pkg::ADDR_STEPCFG: prdata <= {29'h0, stepcfg_q};
        acs_pkg::ADDR_TEST:    prdata <= {24'h000000, test_q};
        default:               prdata <= eq_hit ? {24'h000000, eq_q[eq_idx]} : 32'h0000_0000;
      endcase
    end
  end

  // ---------- checks ----------
  mute_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mst_q == acs_pkg::ACS_MUTE_DOWN && !m_done) |=> mst_q == acs_pkg::ACS_MUTE_DOWN)
    else $error("mute ramp left early");
  mute_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mute_req) && mst_q == acs_pkg::ACS_MUTE_OPEN |=> mute_active)
    else $error("status not set on mute");
  az_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    insel_wr && ctrl_q[acs_pkg::CTRL_KEEP_BIT] && !az_busy |=> !az_busy)
    else $error("cancel started with keep bit");
  az_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    insel_wr && !ctrl_q[acs_pkg::CTRL_KEEP_BIT] |=> az_busy)
    else $error("cancel not started");
  fc_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && req.addr == acs_pkg::ADDR_INSEL |=> !common_input_return)
    else $error("fast charge not released");
  test_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    test_mode |-> ctrl_q[acs_pkg::CTRL_TEST_BIT] && test_q[0])
    else $error("test mode without both bits");
  band_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    sac_rise && cyc_q && band_q < 3'h6 |=> band_q == $past(band_q) + 3'h1 || $past(band_q) == 3'h7)
    else $error("band did not step");
  cycle_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    sac_fall && !cyc_q |=> cyc_q && band_q == 3'h7)
    else $error("read cycle not started");
  vol_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    volume_q <= acs_pkg::VOL_MAX_CODE)
    else $error("volume out of range");
  eq_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    !eq_q[1].fsel && !eq_q[2].fsel && !eq_q[3].fsel && !eq_q[4].fsel)
    else $error("fixed band has centre select");

  mute_cycle_c: cover property (@(posedge pclk) disable iff (!presetn)
    mst_q == acs_pkg::ACS_MUTE_UP ##1 mst_q == acs_pkg::ACS_MUTE_OPEN);
  sa_clear_c: cover property (@(posedge pclk) disable iff (!presetn) sa_clear);
  az_run_c: cover property (@(posedge pclk) disable iff (!presetn) az_done);
  step_c: cover property (@(posedge pclk) disable iff (!presetn) s_start);
endmodule : acs_top

// ==== dv/acs_host.sv ====
// acs_host: host model that clocks the analyzer readout
// assumes pclk at 200 MHz; counts shortened to match the bench
`timescale 1ns/1ps
module acs_host #(
  parameter int unsigned DEL_CYC = 400, // output delay, 2 us
  parameter int unsigned RST_CYC = 520  // above the reset hold
) (
  input  wire logic       pclk,               // clock
  input  wire logic [7:0] analyzer_level_out, // level to sample
  output logic            analyzer_read_clock // read clock
);
  logic [7:0] lvl_q [7];
  initial analyzer_read_clock = 1'b1;
  // also serves as spacing between read cycles
  task automatic hold_high();
    analyzer_read_clock <= 1'b1;
    repeat (RST_CYC) @(posedge pclk);
  endtask : hold_high
  task automatic read_cycle();
    analyzer_read_clock <= 1'b0;
    repeat (8) @(posedge pclk);
    for (int b = 0; b < 7; b++) begin
      analyzer_read_clock <= 1'b1;
      repeat (DEL_CYC) @(posedge pclk);
      lvl_q[b] = analyzer_level_out;
      if (b < 6) begin
        analyzer_read_clock <= 1'b0;
        repeat (8) @(posedge pclk);
      end
    end
  endtask : read_cycle
endmodule : acs_host

// ==== dv/testbench.sv ====
// testbench: APB scenarios plus host model on the read clock
// assumes shortened counts handed to acs_top as parameters
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic        pclk, presetn, psel, penable;
  logic        pwrite, soft_mute_pin, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [55:0] band_level, eq_cfg;
  logic [7:0]  analyzer_level_out, volume_code;
  logic [3:0]  input_gain;
  logic        pready, pslverr, analyzer_read_clock, mute_active, mute_gain_down;
  logic        offset_cancel, common_input_return, soft_step_busy, test_mode;
  int          n_fail = 0, cmp_count = 0;
  always #2.5 pclk = ~pclk;
  acs_top #(.INTRES_CYC(500), .AZ_CYC(10), .MUTE_T1(8), .MUTE_T2(16), .MUTE_T3(24),
    .STEP_T0(4), .STEP_T1(8), .STEP_T2(12), .STEP_T3(16)) u_acs_top (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .analyzer_read_clock, .soft_mute_pin, .band_level, .analyzer_level_out, .mute_active,
    .mute_gain_down, .offset_cancel, .common_input_return, .soft_step_busy, .test_mode,
    .input_gain, .volume_code, .eq_cfg);
  acs_host u_acs_host (.pclk, .analyzer_level_out, .analyzer_read_clock);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic t_mute();
    int n;
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, acs_pkg::ADDR_MUTECFG, 32'(t * 2 + 1));
      repeat (80) @(posedge pclk);
      `CHK(mute_active, 1'b0)
      soft_mute_pin <= 1'b0;
      repeat (2) @(posedge pclk);
      soft_mute_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      `CHK(mute_gain_down, 1'b1)
      n = 0;
      while (mute_gain_down === 1'b1 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      `CHK(n + 8 >= 8 * (t + 1) && n <= 8 * (t + 1) + 4, 1'b1)
      `CHK(mute_active, 1'b1)
    end
    apb(1'b1, acs_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, acs_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0);
    repeat (100) @(posedge pclk);
    `CHK(mute_active, 1'b0)
  endtask : t_mute
  task automatic t_regs();
    apb(1'b1, acs_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, acs_pkg::ADDR_INSEL, 32'h2B);
    `CHK({offset_cancel, common_input_return}, 2'b10)
    `CHK(input_gain, 4'h5)
    `CHK(mute_active, 1'b1)
    repeat (12) @(posedge pclk);
    `CHK(offset_cancel, 1'b0)
    apb(1'b1, acs_pkg::ADDR_CTRL, 32'h40);
    apb(1'b1, acs_pkg::ADDR_INSEL, 32'h3);
    `CHK(offset_cancel, 1'b0)
    apb(1'b1, acs_pkg::ADDR_CTRL, 32'h80);
    `CHK(test_mode, 1'b0)
    apb(1'b1, acs_pkg::ADDR_TEST, 32'h1);
    `CHK(test_mode, 1'b1)
    apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0);
    `CHK(test_mode, 1'b0)
    apb(1'b1, acs_pkg::ADDR_VOLUME, 32'hFF);
    `CHK(volume_code, 8'hDF)
    apb(1'b1, acs_pkg::ADDR_VOLUME, 32'h0);
    `CHK(soft_step_busy, 1'b0)
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, acs_pkg::ADDR_STEPCFG, 32'(t * 2 + 1));
      apb(1'b1, acs_pkg::ADDR_VOLUME, 32'(t + 1));
      `CHK(soft_step_busy, 1'b1)
      repeat (20) @(posedge pclk);
      `CHK(soft_step_busy, 1'b0)
    end
    for (int b = 0; b < 7; b++) begin
      apb(1'b1, acs_pkg::ADDR_EQ0 + 12'(4 * b), 32'hFF);
      `CHK(eq_cfg[8*b+:8], (b == 0 || b > 4) ? 8'hFF : 8'h7F)
    end
    apb(1'b0, 12'h100, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask : t_regs
  task automatic t_spec();
    u_acs_host.hold_high();
    for (int b = 0; b < 7; b++) band_level[8*b+:8] <= 8'(16 * b + 9);
    repeat (4) @(posedge pclk);
    band_level <= 56'h0;
    u_acs_host.read_cycle();
    for (int b = 0; b < 7; b++) `CHK(u_acs_host.lvl_q[b], 8'(16 * b + 9))
    u_acs_host.hold_high();
    u_acs_host.read_cycle();
    for (int b = 0; b < 7; b++) `CHK(u_acs_host.lvl_q[b], 8'h00)
  endtask : t_spec
  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #300000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    soft_mute_pin = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    band_level = 56'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({common_input_return, input_gain, volume_code}, 13'h1FDE)
    t_mute();
    t_regs();
    t_spec();
    report_and_stop();
  end
endmodule : testbench
